// >>> verilog/cls_interconnect.sv
/*
  interconnect end for one master port: sequences a request, drives
  snoops from a user snoop port, and interlocks response with snoop.
  assumes the master end on cls_link_if and a user that wants to snoop.
  holds one request and one snoop outstanding at a time.
*/
// Operation
// - one global order per cache line
// - any arbitration picks who goes first
// - snoop before response orders snoop first
// - response before snoop orders request first
// - interlocks compare same cache line only
// - no snoop after response until ack
// - no response after snoop until crresp
// - master acks every read and write
// - rack only after last read beat
// - wack only after write response
// - acks taken the cycle they arrive
// - static continuous read option, default false
// - option on: remaining beats always delivered
// - master may stall snoops mid line read; here snp_ready is ignored and the master never stalls
// - started snoop data finishes fully
// - which reads continuous return covers
// - continuous read recommended, not required
// - snoop, collect, access memory, respond
// - several outstanding requests and snoops allowed; here one request and one snoop at a time
`timescale 1ns/1ps
module cls_interconnect #(
  parameter logic CONT_READ = cls_pkg::CLS_CONT_READ_DEFAULT
) (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // link
  cls_link_if.ic link,
  // user snoop request
  input wire logic usr_snp_valid,
  input wire logic [cls_pkg::CLS_ADDR_W-1:0] usr_snp_addr,
  output logic usr_snp_taken,
  // memory data for responses
  input wire logic [cls_pkg::CLS_DATA_W-1:0] mem_data,
  // observation
  output logic ack_seen,
  output logic [cls_pkg::CLS_RESP_W-1:0] snp_result
);
  import cls_pkg::*;
  // sequencer, response and snoop state
  typedef enum logic [1:0] {CLS_IDLE, CLS_HOLD, CLS_BEAT, CLS_ACKW} cls_st_t;
  cls_st_t st, next_st;
  logic [CLS_TAG_W-1:0] req_tag, next_req_tag, snp_tag, next_snp_tag;
  logic req_coh, next_req_coh, cont, next_cont;
  logic [CLS_BEAT_W-1:0] beat, next_beat;
  logic rsp_v, next_rsp_v, rsp_l, next_rsp_l;
  logic [CLS_DATA_W-1:0] rsp_d, next_rsp_d;
  logic snp_v, next_snp_v, snp_wait, next_snp_wait;
  logic [CLS_ADDR_W-1:0] snp_a, next_snp_a;
  logic rdy, next_rdy, taken, next_taken, ack, next_ack;
  logic [CLS_RESP_W-1:0] sres, next_sres;
  logic kind_coh, kind_cont, same_line, new_snp_line;

  // classify incoming request kinds
  always_comb begin
    // no-snoop kinds skip every interlock
    kind_coh = link.req_kind != CLS_RD_NOSNOOP &&
      link.req_kind != CLS_WR_NOSNOOP;
    case (link.req_kind)
      CLS_RD_CLEAN, CLS_RD_SHARED, CLS_RD_UNIQUE,
      CLS_RD_NOTSHDIRTY: kind_cont = 1'b1;
      CLS_RD_ONCE: kind_cont = link.req_full_line;
      CLS_RD_NOSNOOP: kind_cont = link.req_full_line &&
        link.req_cacheable;
      default: kind_cont = 1'b0;
    endcase
  end
  // line compare only, low address bits ignored
  assign same_line = snp_tag == req_tag;
  // same test for a snoop that is still only requested
  assign new_snp_line = usr_snp_addr[CLS_ADDR_W-1:CLS_LINE_LSB] == req_tag;

  // sequencer next state
  always_comb begin
    next_st = st;
    next_req_tag = req_tag;
    next_req_coh = req_coh;
    next_cont = cont;
    next_beat = beat;
    next_rsp_v = 1'b0;
    next_rsp_l = 1'b0;
    next_rsp_d = rsp_d;
    next_snp_v = 1'b0;
    next_snp_wait = snp_wait;
    next_snp_a = snp_a;
    next_snp_tag = snp_tag;
    next_rdy = 1'b0;
    next_taken = 1'b0;
    next_ack = 1'b0;
    next_sres = sres;
    // crresp closes the snoop-awaiting-response flag
    // and frees the port for the next snoop
    if (link.crresp_valid) begin
      next_snp_wait = 1'b0;
      next_sres = link.crresp;
    end
    // issue a snoop unless a same-line coherent response is in flight;
    // from the beat phase to the ack the line belongs to the master,
    // and a snoop there would be ordered both before and after it
    if (usr_snp_valid && !snp_wait && !snp_v &&
        !((st == CLS_BEAT || st == CLS_ACKW) && req_coh &&
          new_snp_line)) begin
      next_snp_v = 1'b1;
      next_snp_wait = 1'b1;
      next_snp_a = usr_snp_addr;
      next_snp_tag = usr_snp_addr[CLS_ADDR_W-1:CLS_LINE_LSB];
      next_taken = 1'b1;
    end
    case (st)
      CLS_IDLE: begin
        // one port here, so arbitration is simply first come
        next_rdy = 1'b1;
        if (rdy && link.req_valid) begin
          next_rdy = 1'b0;
          next_req_tag = link.req_addr[CLS_ADDR_W-1:CLS_LINE_LSB];
          next_req_coh = kind_coh;
          next_cont = CONT_READ && !link.req_write && kind_cont;
          next_beat = CLS_BEAT_RST;
          next_st = CLS_HOLD;
        end
      end
      CLS_HOLD: begin
        // wait out any same-line snoop before answering
        // a snoop that went out first is ordered first
        if (!(req_coh && (snp_wait || snp_v) && same_line)) begin
          next_st = CLS_BEAT;
        end
      end
      CLS_BEAT: begin
        // the first beat waits for a same-line crresp even with the
        // option on; once it is out no snoop can stall the rest
        if ((cont && beat != CLS_BEAT_RST) ||
            !(req_coh && snp_wait && same_line)) begin
          next_rsp_v = 1'b1;
          next_rsp_d = mem_data;
          next_beat = beat + 2'h1;
          if (beat == CLS_LAST_BEAT) begin
            next_rsp_l = 1'b1;
            next_st = CLS_ACKW;
          end
        end
      end
      CLS_ACKW: begin
        // acks cannot be stalled, so take them the cycle they arrive
        if (link.rack || link.wack) begin
          next_ack = 1'b1;
          next_st = CLS_IDLE;
        end
      end
      default: next_st = CLS_IDLE;
    endcase
  end

  // register sequencer state
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      st <= CLS_IDLE;
      req_tag <= '0;
      req_coh <= 1'b0;
      cont <= 1'b0;
      beat <= CLS_BEAT_RST;
      rsp_v <= 1'b0;
      rsp_l <= 1'b0;
      rsp_d <= '0;
      snp_v <= 1'b0;
      snp_wait <= 1'b0;
      snp_a <= '0;
      snp_tag <= '0;
      rdy <= 1'b0;
      taken <= 1'b0;
      ack <= 1'b0;
      sres <= '0;
    end else begin
      st <= next_st;
      req_tag <= next_req_tag;
      req_coh <= next_req_coh;
      cont <= next_cont;
      beat <= next_beat;
      rsp_v <= next_rsp_v;
      rsp_l <= next_rsp_l;
      rsp_d <= next_rsp_d;
      snp_v <= next_snp_v;
      snp_wait <= next_snp_wait;
      snp_a <= next_snp_a;
      snp_tag <= next_snp_tag;
      rdy <= next_rdy;
      taken <= next_taken;
      ack <= next_ack;
      sres <= next_sres;
    end
  end

  // link and observation outputs come straight from registers
  assign link.req_ready = rdy;
  assign link.rsp_valid = rsp_v;
  assign link.rsp_last = rsp_l;
  assign link.rsp_data = rsp_d;
  assign link.snp_valid = snp_v;
  assign link.snp_addr = snp_a;
  assign usr_snp_taken = taken;
  assign ack_seen = ack;
  assign snp_result = sres;
endmodule

// >>> verilog/cls_pkg.sv
/*
  package for the coherent line sequencer: sizes, transaction kinds,
  cache line geometry and the static continuous-read option.
  assumes nothing beyond a SystemVerilog compiler.
*/
package cls_pkg;
  localparam int CLS_MASTERS = 2;
  localparam int CLS_ADDR_W = 16;
  localparam int CLS_LINE_LSB = 6;
  localparam int CLS_TAG_W = CLS_ADDR_W - CLS_LINE_LSB;
  localparam int CLS_BEATS = 4;
  localparam int CLS_BEAT_W = 2;
  localparam logic [CLS_BEAT_W-1:0] CLS_LAST_BEAT = 2'h3;
  localparam int CLS_DATA_W = 32;
  localparam int CLS_RESP_W = 5;
  localparam logic [CLS_BEAT_W-1:0] CLS_BEAT_RST = 2'h0;
  // static option: undeclared means false
  localparam logic CLS_CONT_READ_DEFAULT = 1'b0;

  typedef enum logic [3:0] {
    CLS_RD_NOSNOOP, CLS_RD_ONCE, CLS_RD_CLEAN, CLS_RD_NOTSHDIRTY,
    CLS_RD_SHARED, CLS_RD_UNIQUE, CLS_CLEAN_UNIQUE, CLS_MAKE_UNIQUE,
    CLS_CLEAN_SHARED, CLS_CLEAN_INVALID, CLS_MAKE_INVALID, CLS_WR_UNIQUE,
    CLS_WR_NOSNOOP
  } cls_kind_t;
endpackage

// >>> verilog/cls_link_if.sv
/*
  interface joining the interconnect end and the master end.
  assumes one shared clock mclk; the bench ties both ends to it.
*/
`timescale 1ns/1ps
interface cls_link_if;
  import cls_pkg::*;
  // request from master
  logic req_valid;
  logic req_ready;
  logic req_write;
  cls_kind_t req_kind;
  logic [CLS_ADDR_W-1:0] req_addr;
  logic req_full_line;
  logic req_cacheable;
  // response / read data to master
  logic rsp_valid;
  logic rsp_last;
  logic [CLS_DATA_W-1:0] rsp_data;
  logic rack;
  logic wack;
  // snoop to master
  logic snp_valid;
  logic snp_ready;
  logic [CLS_ADDR_W-1:0] snp_addr;
  logic crresp_valid;
  logic [CLS_RESP_W-1:0] crresp;
  modport ic (input req_valid, req_write, req_kind, req_addr,
    req_full_line, req_cacheable, rack, wack, snp_ready, crresp_valid,
    crresp, output req_ready, rsp_valid, rsp_last, rsp_data, snp_valid,
    snp_addr);
  modport mst (output req_valid, req_write, req_kind, req_addr,
    req_full_line, req_cacheable, rack, wack, snp_ready, crresp_valid,
    crresp, input req_ready, rsp_valid, rsp_last, rsp_data, snp_valid,
    snp_addr);
endinterface

// >>> verilog/cls_master.sv
/*
  master end: issues one request at a time from its user port, answers
  snoops with a crresp one cycle after taking them, and derives rack and
  wack purely from the response handshake.
  assumes the interconnect end on the other side of cls_link_if.
*/
`timescale 1ns/1ps
module cls_master (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // link
  cls_link_if.mst link,
  // user request
  input wire logic usr_valid,
  input wire logic usr_write,
  input wire cls_pkg::cls_kind_t usr_kind,
  input wire logic [cls_pkg::CLS_ADDR_W-1:0] usr_addr,
  input wire logic usr_full_line,
  input wire logic usr_cacheable,
  input wire logic [cls_pkg::CLS_RESP_W-1:0] usr_snp_resp,
  output logic usr_busy,
  output logic usr_done
);
  import cls_pkg::*;
  logic busy, next_busy;
  logic wr, next_wr;
  cls_kind_t kind, next_kind;
  logic [CLS_ADDR_W-1:0] addr, next_addr;
  logic fl, next_fl, cc, next_cc;
  logic rack_q, next_rack, wack_q, next_wack, done, next_done;
  logic snp_pend, next_snp_pend;
  logic [CLS_RESP_W-1:0] snp_resp, next_snp_resp;

  // next request, acknowledge and snoop answer state
  always_comb begin
    next_busy = busy;
    next_wr = wr;
    next_kind = kind;
    next_addr = addr;
    next_fl = fl;
    next_cc = cc;
    next_rack = 1'b0;
    next_wack = 1'b0;
    next_done = 1'b0;
    next_snp_pend = 1'b0;
    next_snp_resp = snp_resp;
    if (!busy && usr_valid) begin
      next_busy = 1'b1;
      next_wr = usr_write;
      next_kind = usr_kind;
      next_addr = usr_addr;
      next_fl = usr_full_line;
      next_cc = usr_cacheable;
    end
    if (busy && !link.req_ready && link.rsp_valid && link.rsp_last) begin
      next_busy = 1'b0;
      next_done = 1'b1;
      next_rack = !wr;
      next_wack = wr;
    end
    // one-cycle snoop turnaround
    if (link.snp_valid) begin
      next_snp_pend = 1'b1;
      next_snp_resp = usr_snp_resp;
    end
  end

  // register master state
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      busy <= 1'b0;
      wr <= 1'b0;
      kind <= CLS_RD_NOSNOOP;
      addr <= '0;
      fl <= 1'b0;
      cc <= 1'b0;
      rack_q <= 1'b0;
      wack_q <= 1'b0;
      done <= 1'b0;
      snp_pend <= 1'b0;
      snp_resp <= '0;
    end else begin
      busy <= next_busy;
      wr <= next_wr;
      kind <= next_kind;
      addr <= next_addr;
      fl <= next_fl;
      cc <= next_cc;
      rack_q <= next_rack;
      wack_q <= next_wack;
      done <= next_done;
      snp_pend <= next_snp_pend;
      snp_resp <= next_snp_resp;
    end
  end

  // link drive; req held valid until taken with req_ready
  logic req_sent, next_req_sent;
  always_comb begin
    next_req_sent = req_sent;
    if (!busy) begin
      next_req_sent = 1'b0;
    end else if (link.req_valid && link.req_ready) begin
      next_req_sent = 1'b1;
    end
  end
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      req_sent <= 1'b0;
    end else begin
      req_sent <= next_req_sent;
    end
  end
  assign link.req_valid = busy && !req_sent;
  assign link.req_write = wr;
  assign link.req_kind = kind;
  assign link.req_addr = addr;
  assign link.req_full_line = fl;
  assign link.req_cacheable = cc;
  assign link.rack = rack_q;
  assign link.wack = wack_q;
  // snoops are never held off, not even during a line read
  assign link.snp_ready = 1'b1;
  assign link.crresp_valid = snp_pend;
  assign link.crresp = snp_resp;
  assign usr_busy = busy;
  assign usr_done = done;
endmodule

// >>> dv/cls_link_properties.sv
/*
  checker for the link between the sequencer ends.
  assumes one clock mclk and a synchronous active-low resetn.
*/
`timescale 1ns/1ps
module cls_link_properties (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // link signals
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic req_write,
  input wire cls_pkg::cls_kind_t req_kind,
  input wire logic [cls_pkg::CLS_ADDR_W-1:0] req_addr,
  input wire logic rsp_valid,
  input wire logic rsp_last,
  input wire logic rack,
  input wire logic wack,
  input wire logic snp_valid,
  input wire logic [cls_pkg::CLS_ADDR_W-1:0] snp_addr,
  input wire logic crresp_valid
);
  import cls_pkg::*;
  logic [CLS_TAG_W-1:0] line, next_line, sline, next_sline;
  logic coh, next_coh, wr, next_wr, busy, next_busy, swait, next_swait;
  logic [CLS_BEAT_W-1:0] beat, next_beat;
  logic same;
  // track request line, kind, response and snoop progress
  always_comb begin
    next_line = line;
    next_coh = coh;
    next_wr = wr;
    if (req_valid && req_ready) begin
      next_line = req_addr[CLS_ADDR_W-1:CLS_LINE_LSB];
      next_coh = req_kind != CLS_RD_NOSNOOP && req_kind != CLS_WR_NOSNOOP;
      next_wr = req_write;
    end
    next_sline = snp_valid ? snp_addr[CLS_ADDR_W-1:CLS_LINE_LSB] : sline;
    next_busy = (busy || rsp_valid) && !(rack || wack);
    next_swait = (swait || snp_valid) && !crresp_valid;
    next_beat = rsp_valid ? beat + 2'h1 : beat;
  end
  // registers only
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      {line, sline, coh, wr, busy, swait, beat} <= '0;
    end else begin
      {line, sline, coh, wr} <= {next_line, next_sline, next_coh, next_wr};
      {busy, swait, beat} <= {next_busy, next_swait, next_beat};
    end
  end
  assign same = snp_addr[CLS_ADDR_W-1:CLS_LINE_LSB] == line;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  snoop_hold_off_a: assert property (
    (busy || rsp_valid) && coh && same |-> !snp_valid)
    else $error("snoop during same line response");
  rsp_hold_off_a: assert property (
    swait && coh && sline == line && beat == 2'h0 |-> !rsp_valid)
    else $error("response while snoop awaits reply");
  beats_four_a: assert property (
    $rose(rsp_valid) |-> rsp_valid [*4] ##0 rsp_last)
    else $error("line beats not back to back");
  last_beat_a: assert property (
    rsp_last |-> rsp_valid && beat == CLS_LAST_BEAT)
    else $error("last flag on wrong beat");
  ack_after_last_a: assert property (
    rack || wack |-> $past(rsp_last))
    else $error("ack not right after last beat");
  ack_kind_a: assert property (
    rsp_last |=> (wr ? wack && !rack : rack && !wack))
    else $error("wrong or missing ack");
  crresp_reply_a: assert property (
    snp_valid |=> crresp_valid)
    else $error("snoop reply missing");
  resp_bound_a: assert property (
    req_valid && req_ready |-> ##[2:40] rsp_valid)
    else $error("no response to request");
  cover property (snp_valid && busy);
  cover property (swait && rsp_valid);
  cover property (wack);
endmodule

// >>> dv/coherent_line_sequencer_bench.sv
/*
  bench: both ends joined by cls_link_if, driven from user ports.
  assumes the design files and the checker are compiled first.
*/
`timescale 1ns/1ps
module coherent_line_sequencer_bench;
  import cls_pkg::*;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic usr_valid = 1'b0;
  logic usr_write = 1'b0;
  cls_kind_t usr_kind = CLS_RD_NOSNOOP;
  logic [CLS_ADDR_W-1:0] usr_addr = 16'h0;
  logic [CLS_RESP_W-1:0] usr_snp_resp = 5'h0;
  logic usr_snp_valid = 1'b0;
  logic [CLS_ADDR_W-1:0] usr_snp_addr = 16'h0;
  logic [CLS_DATA_W-1:0] mem_data = 32'h0;
  logic usr_full_line = 1'b1;
  logic usr_cacheable = 1'b1;
  logic usr_busy, usr_done, usr_snp_taken, ack_seen;
  logic [CLS_RESP_W-1:0] snp_result;
  int error_cnt = 0;
  int tests_run = 0;
  time t_taken, t_done;
  cls_link_if link ();
  always #50 mclk = ~mclk;
  cls_interconnect #(.CONT_READ(1'b0)) cls_interconnect_i (.mclk(mclk),
    .resetn(resetn), .link(link.ic), .usr_snp_valid(usr_snp_valid),
    .usr_snp_addr(usr_snp_addr), .usr_snp_taken(usr_snp_taken),
    .mem_data(mem_data), .ack_seen(ack_seen), .snp_result(snp_result));
  cls_master cls_master_i (.mclk(mclk), .resetn(resetn), .link(link.mst),
    .usr_valid(usr_valid), .usr_write(usr_write), .usr_kind(usr_kind),
    .usr_addr(usr_addr), .usr_full_line(usr_full_line),
    .usr_cacheable(usr_cacheable),
    .usr_snp_resp(usr_snp_resp), .usr_busy(usr_busy), .usr_done(usr_done));
  cls_link_properties cls_link_properties_i (.mclk(mclk), .resetn(resetn),
    .req_valid(link.req_valid), .req_ready(link.req_ready),
    .req_write(link.req_write), .req_kind(link.req_kind),
    .req_addr(link.req_addr), .rsp_valid(link.rsp_valid),
    .rsp_last(link.rsp_last), .rack(link.rack), .wack(link.wack),
    .snp_valid(link.snp_valid), .snp_addr(link.snp_addr),
    .crresp_valid(link.crresp_valid));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("counts: %0d checks, %0d wrong", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // one request to completion, then the ack must be taken
  task automatic do_req(input logic wr, input cls_kind_t k,
      input logic [CLS_ADDR_W-1:0] a);
    int n;
    n = 0;
    {usr_write, usr_kind, usr_addr} = {wr, k, a};
    mem_data = {16'h5a5a, a};
    usr_valid = 1'b1;
    while (usr_busy !== 1'b1 && n < 50) begin
      @(posedge mclk);
      #1 n++;
    end
    usr_valid = 1'b0;
    while (usr_done !== 1'b1 && n < 100) begin
      @(posedge mclk);
      #1 n++;
    end
    t_done = $time;
    chk(32'(usr_done), 32'h1);
    chk(32'(usr_busy), 32'h0);
    @(posedge mclk);
    #1 chk(32'(ack_seen), 32'h1);
  endtask
  // one snoop, then its reply value must be seen
  task automatic do_snp(input logic [CLS_ADDR_W-1:0] a,
      input logic [CLS_RESP_W-1:0] r);
    int n;
    n = 0;
    {usr_snp_addr, usr_snp_resp} = {a, r};
    usr_snp_valid = 1'b1;
    while (usr_snp_taken !== 1'b1 && n < 100) begin
      @(posedge mclk);
      #1 n++;
    end
    t_taken = $time;
    chk(32'(usr_snp_taken), 32'h1);
    usr_snp_valid = 1'b0;
    repeat (3) @(posedge mclk);
    #1 chk(32'(snp_result), 32'(r));
  endtask
  // every beat carries the memory word
  always @(posedge mclk)
    if (link.rsp_valid === 1'b1)
      chk(link.rsp_data, mem_data);
  initial begin
    #100_000;
    error_cnt++;
    give_verdict();
  end
  initial begin
    repeat (2) @(posedge mclk);
    #1 resetn = 1'b1;
    @(posedge mclk);
    #1 mem_data = 32'h5a5a0001;
    for (int k = 0; k < 13; k++) begin
      usr_full_line = k[0];
      usr_cacheable = k[1];
      do_req(k >= 11, cls_kind_t'(k), 16'(k << 6));
    end
    usr_full_line = 1'b1;
    usr_cacheable = 1'b1;
    $display("test kinds done");
    fork
      do_req(1'b0, CLS_RD_UNIQUE, 16'h1000);
      begin
        @(posedge link.rsp_valid);
        #1 do_snp(16'h2000, 5'h01);
      end
    join
    chk(32'(t_taken < t_done), 32'h1);
    $display("test other line done");
    fork
      do_req(1'b0, CLS_RD_SHARED, 16'h3000);
      begin
        @(posedge link.rsp_valid);
        #1 do_snp(16'h3000, 5'h0c);
      end
    join
    chk(32'(t_taken > t_done), 32'h1);
    $display("test response first done");
    fork
      do_snp(16'h4000, 5'h1e);
      do_req(1'b1, CLS_WR_UNIQUE, 16'h4010);
    join
    chk(32'(t_taken < t_done), 32'h1);
    // hold lasts until crresp, so the answer ends eight cycles on
    chk(32'(t_done - t_taken), 32'h320);
    $display("test snoop first done");
    give_verdict();
  end
endmodule
